// ==== logic/sctg_top.v ====
/*
  Serial cycle timing generator: oscillator-rate tick, complementary
  source pair, three redundant divider channels, voted timing outputs,
  instruction/operation time and decoded strobes.
  Assumes clk at 125 MHz; the 2.048 MHz source is made by a fractional
  accumulator so its mean rate is exact.
*/
`timescale 1ns/10ps
`include "sctg_defs.vh"

module sctg_top #(
  parameter CHANNELS = 3
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Complementary source pair.
  output reg divider_source_clock,
  output reg delay_line_drive_clock,
  // Quarter clock strobes, one slot wide each.
  output reg clk_w,
  output reg clk_x,
  output reg clk_y,
  output reg clk_z,
  // Voted timing state.
  output reg [1:0] phase,
  output reg [3:0] bit_time,
  output reg [`SCTG_GATES-1:0] timing_gate,
  output reg instruction_time,
  output reg operation_time,
  // Serial storage shift and syllable framing.
  output reg shift_bit,
  output reg syllable_start,
  output reg cycle_start,
  // Decoded strobes.
  output reg strobe_every_phase,
  output reg strobe_phase_qual,
  // Channel disagreement flag.
  output reg vote_mismatch
);

  ////////////////////////////////////////////////////////////////////
  // Source tick at twice the oscillator rate via phase accumulator.

  // Step is the source half periods per ms (twice the source kHz), modulus the clk rate per ms.
  localparam integer ACC_STEP_I = 2 * `SCTG_SRC_KHZ;
  localparam integer ACC_MOD_I = `SCTG_CLK_KHZ;
  localparam [17:0] ACC_STEP = ACC_STEP_I[17:0];
  localparam [17:0] ACC_MOD = ACC_MOD_I[17:0];
  // The mean source rate is exact, but single half periods are 30 or 31
  // clocks, so every source edge carries up to one clock of jitter and a
  // full cycle of 168 source periods lasts 10253 or 10254 clocks.

  reg [17:0] acc_q;
  reg [17:0] acc_d;
  reg half_tick;
  reg src_en;

  // Accumulate; each wrap is one half period of the source.
  always @* begin
    acc_d = acc_q + ACC_STEP;
    half_tick = 1'b0;
    if (acc_d >= ACC_MOD) begin
      acc_d = acc_d - ACC_MOD;
      half_tick = 1'b1;
    end
  end

  // Toggle the complementary pair; the divider tick is the rising half.
  always @(posedge clk) begin
    if (srst) begin
      acc_q <= 18'h00000;
      divider_source_clock <= 1'b0;
      delay_line_drive_clock <= 1'b1;
      src_en <= 1'b0;
    end else begin
      acc_q <= acc_d;
      src_en <= half_tick && !divider_source_clock;
      if (half_tick) begin
        divider_source_clock <= ~divider_source_clock;
        delay_line_drive_clock <= divider_source_clock;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Three redundant channels fed by the shared tick.

  wire [2*CHANNELS-1:0] ch_quarter;
  wire [2*CHANNELS-1:0] ch_phase;
  wire [`SCTG_GATES*CHANNELS-1:0] ch_gate;
  wire [4*CHANNELS-1:0] ch_bit;
  wire [CHANNELS-1:0] ch_bit_end;
  wire [CHANNELS-1:0] ch_phase_end;
  wire [CHANNELS-1:0] ch_cycle_end;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
      // Each channel holds its own divider chain.
      sctg_channel u_ch (
        .clk(clk),
        .srst(srst),
        .src_en(src_en),
        .quarter_q(ch_quarter[2*g+1:2*g]),
        .phase_q(ch_phase[2*g+1:2*g]),
        .gate(ch_gate[`SCTG_GATES*g+`SCTG_GATES-1:`SCTG_GATES*g]),
        .bit_time(ch_bit[4*g+3:4*g]),
        .bit_end(ch_bit_end[g]),
        .phase_end(ch_phase_end[g]),
        .cycle_end(ch_cycle_end[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Majority vote of the first three channels.

  function [15:0] vote3;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    begin
      vote3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // Every channel is packed alike: quarter, phase, bit time, a pad bit, gates.
  wire [16*CHANNELS-1:0] ch_state;
  // Every channel's boundary pulses: bit end, phase end, cycle end.
  wire [3*CHANNELS-1:0] ch_event;

  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_pack
      // Same layout for each channel, so one vote covers every field.
      assign ch_state[16*g+15:16*g] = {ch_quarter[2*g+1:2*g], ch_phase[2*g+1:2*g],
                                       ch_bit[4*g+3:4*g], 1'b0,
                                       ch_gate[`SCTG_GATES*g+`SCTG_GATES-1:`SCTG_GATES*g]};
      assign ch_event[3*g+2:3*g] = {ch_bit_end[g], ch_phase_end[g], ch_cycle_end[g]};
    end
  endgenerate

  // The vote reads channels 0 to 2 only.
  wire [15:0] st0 = ch_state[15:0];
  wire [15:0] st1 = ch_state[31:16];
  wire [15:0] st2 = ch_state[47:32];
  wire [15:0] ev0 = {13'h0000, ch_event[2:0]};
  wire [15:0] ev1 = {13'h0000, ch_event[5:3]};
  wire [15:0] ev2 = {13'h0000, ch_event[8:6]};
  wire [15:0] st_v = vote3(st0, st1, st2);
  // Only the low three bits of the voted event word carry pulses.
  wire [15:0] ev_w = vote3(ev0, ev1, ev2);
  wire [2:0] ev_v = ev_w[2:0];

  wire [1:0] q_v = st_v[15:14];
  wire [1:0] ph_v = st_v[13:12];
  wire [3:0] bit_v = st_v[11:8];
  wire [6:0] gate_v = st_v[6:0];

  ////////////////////////////////////////////////////////////////////
  // Registered outputs from the voted state, except vote_mismatch, which compares the raw channels.

  always @(posedge clk) begin
    if (srst) begin
      clk_w <= 1'b0;
      clk_x <= 1'b0;
      clk_y <= 1'b0;
      clk_z <= 1'b0;
      phase <= `SCTG_PH_A;
      bit_time <= 4'h1;
      timing_gate <= {`SCTG_GATES{1'b0}};
      instruction_time <= 1'b1;
      operation_time <= 1'b0;
      shift_bit <= 1'b0;
      syllable_start <= 1'b0;
      cycle_start <= 1'b0;
      strobe_every_phase <= 1'b0;
      strobe_phase_qual <= 1'b0;
      vote_mismatch <= 1'b0;
    end else begin
      // Quarter slot decode; each repeats once per bit time.
      clk_w <= (q_v == `SCTG_Q_W);
      clk_x <= (q_v == `SCTG_Q_X);
      clk_y <= (q_v == `SCTG_Q_Y);
      clk_z <= (q_v == `SCTG_Q_Z);
      phase <= ph_v;
      bit_time <= bit_v;
      timing_gate <= gate_v;
      // Phase A reads an instruction syllable, B and C the data syllables.
      instruction_time <= (ph_v == `SCTG_PH_A);
      operation_time <= (ph_v != `SCTG_PH_A);
      // Serial storage advances once per bit time.
      shift_bit <= ev_v[2];
      syllable_start <= ev_v[1];
      cycle_start <= ev_v[0];
      // Phase-free strobe at every 6-Z, qualified strobe at A-11-W.
      strobe_every_phase <= (bit_v == `SCTG_STB_BIT) && (q_v == `SCTG_STB_Q);
      strobe_phase_qual <= (ph_v == `SCTG_STB2_PH) && (bit_v == `SCTG_STB2_BIT)
                           && (q_v == `SCTG_STB2_Q);
      vote_mismatch <= (st0 != st1) || (st0 != st2) || (ev0 != ev1) || (ev0 != ev2);
    end
  end

endmodule

// ==== logic/sctg_defs.vh ====
/*
  Timing constants for the serial cycle timing generator.
  Assumes inclusion by bare name from design files under logic/.
*/
`ifndef SCTG_DEFS_VH
`define SCTG_DEFS_VH

// Source rate and the system clock, both in kHz.
`define SCTG_SRC_KHZ 2048
`define SCTG_CLK_KHZ 125000
// Quarter clocks per bit time.
`define SCTG_QUARTERS 4
// Quarter clock encodings.
`define SCTG_Q_W 2'h0
`define SCTG_Q_X 2'h1
`define SCTG_Q_Y 2'h2
`define SCTG_Q_Z 2'h3
// Timing-gate stages and bit times per phase.
`define SCTG_GATES 7
`define SCTG_BITS 14
// Phase encodings.
`define SCTG_PH_A 2'h0
`define SCTG_PH_B 2'h1
`define SCTG_PH_C 2'h2
// Nominal computer cycle in ns (about 82 us).
`define SCTG_CYCLE_NS 82031
// Strobe selections: bit time and quarter for the phase-free strobe.
`define SCTG_STB_BIT 4'h6
`define SCTG_STB_Q 2'h3
// Phase, bit and quarter for the phase-qualified strobe.
`define SCTG_STB2_PH 2'h0
`define SCTG_STB2_BIT 4'hB
`define SCTG_STB2_Q 2'h0

`endif

// ==== logic/sctg_twisted_ring.v ====
/*
  Seven-stage twisted-ring counter that forms the timing gates.
  Assumes a single clock, synchronous reset and a one-cycle advance enable.
*/
`timescale 1ns/10ps
`include "sctg_defs.vh"

module sctg_twisted_ring #(
  parameter STAGES = `SCTG_GATES
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Advance once per bit time.
  input wire adv,
  // Gate outputs and decoded bit time (1 based).
  output reg [STAGES-1:0] gate_q,
  output reg [3:0] bit_time_q
);

  reg [STAGES-1:0] gate_d;

  // Shift left and feed back the inverted top stage.
  always @* begin
    gate_d = {gate_q[STAGES-2:0], ~gate_q[STAGES-1]};
  end

  // Gates and bit number advance together; 2*STAGES distinct states.
  always @(posedge clk) begin
    if (srst) begin
      gate_q <= {STAGES{1'b0}};
      bit_time_q <= 4'h1;
    end else if (adv) begin
      gate_q <= gate_d;
      if (gate_d == {STAGES{1'b0}}) begin
        bit_time_q <= 4'h1;
      end else begin
        bit_time_q <= bit_time_q + 4'h1;
      end
    end
  end

endmodule

// ==== logic/sctg_channel.v ====
/*
  One redundant channel: divide-by-four quarter clocks, twisted-ring
  bit-time gates and divide-by-three phases.
  Assumes a one-cycle source enable at the oscillator rate.
*/
`timescale 1ns/10ps
`include "sctg_defs.vh"

module sctg_channel (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Divider source tick.
  input wire src_en,
  // Timing state.
  output reg [1:0] quarter_q,
  output reg [1:0] phase_q,
  output wire [`SCTG_GATES-1:0] gate,
  output wire [3:0] bit_time,
  // Bit-time boundary and phase boundary pulses.
  output wire bit_end,
  output wire phase_end,
  output wire cycle_end
);

  // Last bit number of a phase, cut to the width of the bit counter.
  localparam integer BITS_I = `SCTG_BITS;
  localparam [3:0] LAST_BIT = BITS_I[3:0];

  wire bit_last;

  // Last quarter of a bit and the last bit of a phase.
  assign bit_end = src_en && (quarter_q == `SCTG_Q_Z);
  assign bit_last = (bit_time == LAST_BIT);
  assign phase_end = bit_end && bit_last;
  assign cycle_end = phase_end && (phase_q == `SCTG_PH_C);

  // Divide the source by four: W, X, Y, Z in fixed order.
  always @(posedge clk) begin
    if (srst) begin
      quarter_q <= `SCTG_Q_W;
    end else if (src_en) begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  // Divide the phase rate by three: A, B, C.
  always @(posedge clk) begin
    if (srst) begin
      phase_q <= `SCTG_PH_A;
    end else if (phase_end) begin
      if (phase_q == `SCTG_PH_C) begin
        phase_q <= `SCTG_PH_A;
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  // Fourteen bit times per phase, one gate step per bit.
  sctg_twisted_ring #(
    .STAGES(`SCTG_GATES)
  ) u_ring (
    .clk(clk),
    .srst(srst),
    .adv(bit_end),
    .gate_q(gate),
    .bit_time_q(bit_time)
  );

endmodule

// ==== verif/sctg_top_sva.sv ====
/* Checker for the timing outputs of sctg_top.
   Assumes a bind to sctg_top, one clock and synchronous srst. */
`timescale 1ns/10ps
`include "sctg_defs.vh"
module sctg_top_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Source pair and quarter clocks.
  input wire logic divider_source_clock,
  input wire logic delay_line_drive_clock,
  input wire logic clk_w,
  input wire logic clk_x,
  input wire logic clk_y,
  input wire logic clk_z,
  // Timing state and framing.
  input wire logic [1:0] phase,
  input wire logic [3:0] bit_time,
  input wire logic [`SCTG_GATES-1:0] timing_gate,
  input wire logic instruction_time,
  input wire logic operation_time,
  input wire logic shift_bit,
  input wire logic syllable_start,
  input wire logic cycle_start,
  input wire logic strobe_every_phase,
  input wire logic strobe_phase_qual,
  input wire logic vote_mismatch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Quarter clocks as one vector, W in bit 0.
  wire [3:0] qv = {clk_z, clk_y, clk_x, clk_w};
  logic [5:0] half_q;
  logic seen_q;
  // Counts clock cycles since the last source edge.
  always @(posedge clk) begin
    if (srst) begin
      half_q <= 6'h00;
      seen_q <= 1'b0;
    end else if ($changed(divider_source_clock)) begin
      half_q <= 6'h01;
      seen_q <= 1'b1;
    end else if (half_q != 6'h3F) begin
      half_q <= half_q + 6'h01;
    end
  end
  src_pair_a: assert property (delay_line_drive_clock == !divider_source_clock) else $error("pair");
  src_half_a: assert property ($changed(divider_source_clock) && seen_q |-> half_q inside {6'h1E, 6'h1F}) else $error("half period");
  qtr_onehot_a: assert property (!$past(srst) |-> $onehot(qv))
    else $error("quarter one-hot");
  qtr_order_a: assert property ($changed(qv) && $past(qv) != 4'h0 |-> qv == {$past(qv[2:0]), $past(qv[3])}) else $error("quarter order");
  qtr_step_a: assert property ($rose(divider_source_clock) |-> ##[1:3] $changed(qv)) else $error("quarter step");
  bit_step_a: assert property ($changed(bit_time) |-> clk_w && bit_time == ($past(bit_time) == 4'hE ? 4'h1 : $past(bit_time) + 4'h1)) else $error("bit step");
  phase_step_a: assert property ($changed(phase) |-> bit_time == 4'h1 && phase == ($past(phase) == 2'h2 ? 2'h0 : $past(phase) + 2'h1)) else $error("phase step");
  time_split_a: assert property (instruction_time == (phase == 2'h0) && operation_time == !instruction_time) else $error("time split");
  gate_ring_a: assert property ($changed(bit_time) |-> timing_gate == {$past(timing_gate[5:0]), ~$past(timing_gate[6])}) else $error("gate ring");
  gate_zero_a: assert property (bit_time == 4'h1 |-> timing_gate == 7'h00) else $error("gate start");
  shift_pulse_a: assert property ($fell(clk_z) |-> $past(shift_bit) && !shift_bit)
    else $error("shift pulse");
  shift_place_a: assert property (shift_bit |-> clk_z ##1 (clk_w && !shift_bit))
    else $error("shift place");
  syl_frame_a: assert property ((syllable_start |-> shift_bit) and (cycle_start |-> syllable_start)) else $error("framing");
  strobe_dec_a: assert property (strobe_every_phase == (bit_time == 4'h6 && clk_z) && strobe_phase_qual == (instruction_time && bit_time == 4'hB && clk_w)) else $error("strobe");
  vote_ok_a: assert property (!vote_mismatch) else $error("vote");
endmodule
bind sctg_top sctg_top_sva u_sva (.clk(clk), .srst(srst),
  .divider_source_clock(divider_source_clock), .delay_line_drive_clock(delay_line_drive_clock),
  .clk_w(clk_w), .clk_x(clk_x), .clk_y(clk_y), .clk_z(clk_z), .phase(phase),
  .bit_time(bit_time), .timing_gate(timing_gate), .instruction_time(instruction_time),
  .operation_time(operation_time), .shift_bit(shift_bit), .syllable_start(syllable_start),
  .cycle_start(cycle_start), .strobe_every_phase(strobe_every_phase),
  .strobe_phase_qual(strobe_phase_qual), .vote_mismatch(vote_mismatch));

// ==== verif/sctg_top_tb_top.sv ====
/* Self-checking bench for sctg_top with random reset points.
   Assumes the checker is bound to the design elsewhere. */
`timescale 1ns/10ps
`include "sctg_defs.vh"
module sctg_top_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] rng = 32'h000001F3; // Xorshift seed, 499.
  int failures = 0;
  int n_compared = 0;
  wire src, dly, cw, cx, cy, cz, it, ot, sh, sy, cs, se, sq, vm;
  wire [1:0] ph;
  wire [3:0] bt;
  wire [6:0] tg;
  sctg_top #(.CHANNELS(3)) DUT (.clk(clk), .srst(srst), .divider_source_clock(src),
    .delay_line_drive_clock(dly), .clk_w(cw), .clk_x(cx), .clk_y(cy), .clk_z(cz),
    .phase(ph), .bit_time(bt), .timing_gate(tg), .instruction_time(it),
    .operation_time(ot), .shift_bit(sh), .syllable_start(sy), .cycle_start(cs),
    .strobe_every_phase(se), .strobe_phase_qual(sq), .vote_mismatch(vm));
  // Clock at 125 MHz.
  initial begin
    forever #4 clk = ~clk;
  end
  // Advances the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Clocks per computer cycle from the source and system rates.
  function automatic int exp_len();
    return `SCTG_BITS * `SCTG_QUARTERS * 3 * `SCTG_CLK_KHZ / `SCTG_SRC_KHZ;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %0d want %0d", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Moves just past the next rising edge, where outputs are settled.
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Counts one computer cycle from one cycle_start pulse to the next.
  task automatic measure();
    int len, wr, syl, shc, ev, pq, tgl, itc, otc, vmc;
    logic pw, pe, pqp, pd;
    len = 0; wr = 0; syl = 0; shc = 0; ev = 0; pq = 0; tgl = 0; itc = 0;
    otc = 0;
    vmc = 0;
    pw = cw; pe = se; pqp = sq; pd = dly;
    while (cs !== 1'b1 || len == 0) begin
      step();
      len++;
      if (len > 20000) begin
        failures++;
        print_verdict();
      end
      wr += (cw === 1'b1 && pw === 1'b0);
      ev += (se === 1'b1 && pe === 1'b0);
      pq += (sq === 1'b1 && pqp === 1'b0);
      tgl += (dly !== pd);
      syl += (sy === 1'b1);
      shc += (sh === 1'b1);
      itc += (it === 1'b1);
      otc += ((it === 1'b1 && ot === 1'b0) || (it === 1'b0 && ot === 1'b1));
      vmc += (vm !== 1'b0);
      pw = cw; pe = se; pqp = sq; pd = dly;
    end
    check(len >= exp_len() && len <= exp_len() + 1, 1);
    check(wr, 3 * `SCTG_BITS);
    check(shc, 3 * `SCTG_BITS);
    check(tgl, 2 * 3 * `SCTG_BITS * `SCTG_QUARTERS);
    check(syl, 3);
    check(ev, 3);
    check(pq, 1);
    check(itc >= len / 3 - 2 && itc <= len / 3 + 2, 1);
    check(otc, len);
    check(vmc, 0);
  endtask
  // Releases reset after 16 clocks, then at random points, checks the start state and cycles.
  initial begin
    for (int r = 0; r < 3; r++) begin
      rng = xs(rng);
      repeat (r == 0 ? 16 : 2 + rng % 8) @(posedge clk);
      srst <= 1'b0;
      step();
      check({ph, bt, tg, it}, {2'h0, 4'h1, 7'h00, 1'b1});
      check({cw, cx, cy, cz, src, dly, vm}, {4'h8, 2'h1, 1'b0});
      // The cycle cut short at reset has its own length; measure from its end.
      for (int w = 0; w < 12000 && cs !== 1'b1; w++) step();
      if (cs !== 1'b1) begin
        failures++;
        print_verdict();
      end
      measure();
      measure();
      rng = xs(rng);
      repeat (rng % 1024) step();
      @(posedge clk);
      srst <= 1'b1;
    end
    print_verdict();
  end
endmodule
